// ### src/hdc_hex_dual_clock_dff.sv
// Six storage bits with two shared rising-edge clock pins and one shared clear pin.
// Assumes the data, clock and clear pins are asynchronous to CLOCK_I and are sampled through two flip-flops.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Six independent bits, each with own data, sharing both clocks and clear.
// - Each bit drives a true output and its logical inverse.
// - Both clocks low: master follows data, outputs hold.
// - Either clock rising with other low, or both rising, loads outputs.
// - Output equals data before edge; rise with other clock high holds.
// - Clear high forces true outputs low regardless of data and clocks.
// - Clear acts without clock activity and beats a simultaneous edge.
module hdc_hex_dual_clock_dff (
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  input wire logic [hdc_pkg::NUM_BITS-1:0] BIT_DATA_IN_I,
  input wire logic CLOCK_IN_FIRST_I,
  input wire logic CLOCK_IN_SECOND_I,
  input wire logic ASYNC_CLEAR_IN_I,
  output logic [hdc_pkg::NUM_BITS-1:0] TRUE_OUT_O,
  output logic [hdc_pkg::NUM_BITS-1:0] INVERTED_OUT_O
);

  hdc_pkg::hdc_pins_t pins_raw;
  hdc_pkg::hdc_pins_t meta_q;
  hdc_pkg::hdc_pins_t sync_q;
  logic clk_a_prev_q;
  logic clk_b_prev_q;
  logic [hdc_pkg::NUM_BITS-1:0] master_q;
  logic [hdc_pkg::NUM_BITS-1:0] master_d;
  logic [hdc_pkg::NUM_BITS-1:0] true_q;
  logic [hdc_pkg::NUM_BITS-1:0] true_d;
  logic [hdc_pkg::NUM_BITS-1:0] inv_q;
  logic [hdc_pkg::NUM_BITS-1:0] inv_d;

  wire logic clk_a_s;
  wire logic clk_b_s;
  wire logic clr_s;
  wire logic [hdc_pkg::NUM_BITS-1:0] data_s;
  wire logic rise_a;
  wire logic rise_b;
  wire logic both_low;
  wire logic load;
  wire logic held_a;
  wire logic held_b;

  assign pins_raw = '{async_clear_in: ASYNC_CLEAR_IN_I, clock_in_second: CLOCK_IN_SECOND_I,
                      clock_in_first: CLOCK_IN_FIRST_I, bit_data_in: BIT_DATA_IN_I};

  // Two-stage pin synchroniser; meta_q feeds only sync_q
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      meta_q <= hdc_pkg::PINS_RESET;
      sync_q <= hdc_pkg::PINS_RESET;
    end else begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
    end
  end

  assign clk_a_s = sync_q.clock_in_first;
  assign clk_b_s = sync_q.clock_in_second;
  assign clr_s = sync_q.async_clear_in;
  assign data_s = sync_q.bit_data_in;

  // Rising edge in the synchronised domain
  function automatic logic rise_of(input logic now_lvl, input logic last_lvl);
    return now_lvl & ~last_lvl;
  endfunction

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      clk_a_prev_q <= hdc_pkg::CLK_RESET;
      clk_b_prev_q <= hdc_pkg::CLK_RESET;
    end else begin
      clk_a_prev_q <= clk_a_s;
      clk_b_prev_q <= clk_b_s;
    end
  end

  assign rise_a = rise_of(clk_a_s, clk_a_prev_q);
  assign rise_b = rise_of(clk_b_s, clk_b_prev_q);
  assign held_a = clk_a_s & clk_a_prev_q;
  assign held_b = clk_b_s & clk_b_prev_q;
  assign both_low = ~clk_a_s & ~clk_b_s;
  // a rise while the other clock stays high is no edge
  assign load = (rise_a & ~clk_b_s) | (rise_b & ~clk_a_s) | (rise_a & rise_b);

  assign master_d = both_low ? data_s : master_q;

  assign true_d = clr_s ? hdc_pkg::TRUE_RESET : (load ? master_q : true_q);

  assign inv_d = ~true_d;

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      master_q <= hdc_pkg::TRUE_RESET;
    end else begin
      master_q <= master_d;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      true_q <= hdc_pkg::TRUE_RESET;
    end else begin
      true_q <= true_d;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      inv_q <= hdc_pkg::INV_RESET;
    end else begin
      inv_q <= inv_d;
    end
  end

  assign TRUE_OUT_O = true_q;
  assign INVERTED_OUT_O = inv_q;

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (SRST_I);

  property p_load_all_bits;
    load && !clr_s |=> TRUE_OUT_O == $past(master_q);
  endproperty
  a_load_all_bits: assert property (p_load_all_bits) else $error("bits not all loaded on edge");

  property p_complement;
    !$past(SRST_I) |-> INVERTED_OUT_O == ~TRUE_OUT_O;
  endproperty
  a_complement: assert property (p_complement) else $error("inverted output not complement");

  property p_hold_low;
    both_low && !clr_s && !$past(load) |=> master_q == $past(data_s) && $stable(TRUE_OUT_O);
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("master or output wrong while clocks low");

  property p_edge_data;
    both_low ##1 (load && !clr_s) |=> TRUE_OUT_O == $past(data_s, 2);
  endproperty
  a_edge_data: assert property (p_edge_data) else $error("output not data before edge");

  property p_other_high;
    ((rise_a && held_b) || (rise_b && held_a)) && !clr_s |=> $stable(TRUE_OUT_O);
  endproperty
  a_other_high: assert property (p_other_high) else $error("rise with other clock high changed output");

  property p_clear_pin;
    ASYNC_CLEAR_IN_I [*3] |=> TRUE_OUT_O == hdc_pkg::TRUE_RESET;
  endproperty
  a_clear_pin: assert property (p_clear_pin) else $error("clear pin did not force outputs low");

  property p_clear_wins;
    clr_s && load |=> TRUE_OUT_O == hdc_pkg::TRUE_RESET;
  endproperty
  a_clear_wins: assert property (p_clear_wins) else $error("edge overrode clear");

  property p_clear_inv;
    clr_s |=> INVERTED_OUT_O == hdc_pkg::INV_RESET;
  endproperty
  a_clear_inv: assert property (p_clear_inv) else $error("inverted outputs not high under clear");

  property p_first_edge;
    rise_a && !clk_b_s && !clr_s |=> TRUE_OUT_O == $past(master_q);
  endproperty
  a_first_edge: assert property (p_first_edge) else $error("first clock edge did not load master");

  property p_second_edge;
    rise_b && !clk_a_s && !clr_s |=> TRUE_OUT_O == $past(master_q);
  endproperty
  a_second_edge: assert property (p_second_edge) else $error("second clock edge did not load master");

  property p_both_edge;
    rise_a && rise_b && !clr_s |=> TRUE_OUT_O == $past(master_q);
  endproperty
  a_both_edge: assert property (p_both_edge) else $error("joint clock edge did not load master");

  property p_master_freeze;
    !both_low |=> $stable(master_q);
  endproperty
  a_master_freeze: assert property (p_master_freeze) else $error("master moved while a clock was high");

  property p_quiet_hold;
    !load && !clr_s |=> $stable(TRUE_OUT_O);
  endproperty
  a_quiet_hold: assert property (p_quiet_hold) else $error("output changed without a loading edge");

  property p_clear_pin_inv;
    ASYNC_CLEAR_IN_I [*3] |=> INVERTED_OUT_O == hdc_pkg::INV_RESET;
  endproperty
  a_clear_pin_inv: assert property (p_clear_pin_inv) else $error("clear pin did not force inverted high");

  property p_clear_level;
    clr_s |=> TRUE_OUT_O == hdc_pkg::TRUE_RESET;
  endproperty
  a_clear_level: assert property (p_clear_level) else $error("outputs not low under clear");

  property p_clear_time;
    $rose(ASYNC_CLEAR_IN_I) |-> ##[1:3] (TRUE_OUT_O == hdc_pkg::TRUE_RESET);
  endproperty
  a_clear_time: assert property (p_clear_time) else $error("clear pin took too long to act");

  property p_clear_end;
    $fell(clr_s) && !load |=> TRUE_OUT_O == hdc_pkg::TRUE_RESET;
  endproperty
  a_clear_end: assert property (p_clear_end) else $error("outputs moved when clear ended");

  property p_clear_edge_inv;
    clr_s && load |=> INVERTED_OUT_O == hdc_pkg::INV_RESET;
  endproperty
  a_clear_edge_inv: assert property (p_clear_edge_inv) else $error("edge overrode clear on inverted");

  property p_second_data;
    both_low ##1 (rise_b && !clk_a_s && !clr_s) |=> TRUE_OUT_O == $past(data_s, 2);
  endproperty
  a_second_data: assert property (p_second_data) else $error("output not data before second edge");

endmodule

`default_nettype wire

// ### src/hdc_pkg.sv
// Package for the six-bit dual-clock storage block.
// Assumes one system clock; all pin levels are sampled in that clock's domain.
package hdc_pkg;

  localparam int unsigned NUM_BITS = 6;
  localparam logic [NUM_BITS-1:0] TRUE_RESET = 6'h00;
  localparam logic [NUM_BITS-1:0] INV_RESET = 6'h3f;
  localparam logic CLK_RESET = 1'h0;
  localparam int unsigned SYNC_STAGES = 2;

  // Pin levels that travel together through the synchroniser
  typedef struct packed {
    logic async_clear_in;
    logic clock_in_second;
    logic clock_in_first;
    logic [NUM_BITS-1:0] bit_data_in;
  } hdc_pins_t;

  localparam hdc_pins_t PINS_RESET = '{async_clear_in: 1'h0, clock_in_second: 1'h0,
                                       clock_in_first: 1'h0, bit_data_in: 6'h00};

endpackage

// ### testbench/hdc_pin_drv.sv
// Far-side model: surrounding logic driving data, both clocks and clear.
// Assumes the bench clock; pins change only on its falling edge.
`timescale 1ns/1ns
`default_nettype none
module hdc_pin_drv (
  input wire logic clk_i,
  output var hdc_pkg::hdc_pins_t pins_o
);
  initial pins_o = hdc_pkg::PINS_RESET;
  // Set all pin levels, then hold them for n more cycles
  task automatic put(input logic clr, input logic a, input logic b, input logic [5:0] d, input int n);
    @(negedge clk_i);
    pins_o <= '{async_clear_in: clr, clock_in_second: b, clock_in_first: a, bit_data_in: d};
    repeat (n) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// ### testbench/hex_dual_clock_dff_tb.sv
// Self-checking bench for the six-bit dual-clock storage block.
// Assumes the pin driver model and a 4 ns clock.
`timescale 1ns/1ns
`default_nettype none
module hex_dual_clock_dff_tb;
  logic clk = 1'h0;
  logic srst = 1'h1;
  int miscompares = 0;
  int compares = 0;
  hdc_pkg::hdc_pins_t pins;
  logic [5:0] q;
  logic [5:0] qn;
  initial forever #2 clk = ~clk;
  hdc_pin_drv drv (.clk_i(clk), .pins_o(pins));
  hdc_hex_dual_clock_dff dut (.CLOCK_I(clk), .SRST_I(srst), .BIT_DATA_IN_I(pins.bit_data_in),
    .CLOCK_IN_FIRST_I(pins.clock_in_first), .CLOCK_IN_SECOND_I(pins.clock_in_second),
    .ASYNC_CLEAR_IN_I(pins.async_clear_in), .TRUE_OUT_O(q), .INVERTED_OUT_O(qn));
  task automatic check(input logic [5:0] seen, input logic [5:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic t_load();
    drv.put(0, 0, 0, 6'h2d, 4);
    drv.put(0, 1, 0, 6'h2d, 4);
    check(q, 6'h2d);
    check(qn, 6'h12);
    drv.put(0, 0, 0, 6'h12, 4);
    check(q, 6'h2d);
    drv.put(0, 0, 1, 6'h12, 4);
    check(q, 6'h12);
    drv.put(0, 0, 0, 6'h3c, 4);
    drv.put(0, 1, 1, 6'h3c, 4);
    check(q, 6'h3c);
  endtask
  task automatic t_hold();
    drv.put(0, 0, 0, 6'h01, 4);
    drv.put(0, 1, 0, 6'h01, 4);
    drv.put(0, 1, 0, 6'h3e, 4);
    drv.put(0, 1, 1, 6'h3e, 4);
    check(q, 6'h01);
    check(qn, 6'h3e);
    drv.put(0, 0, 0, 6'h2a, 4);
    check(q, 6'h01);
    drv.put(1, 0, 1, 6'h2a, 4);
    check(q, 6'h00);
    drv.put(0, 0, 1, 6'h2a, 4);
    drv.put(0, 1, 1, 6'h2a, 4);
    check(q, 6'h00);
    check(qn, 6'h3f);
  endtask
  task automatic t_clear();
    drv.put(0, 0, 0, 6'h15, 4);
    drv.put(1, 1, 0, 6'h15, 4);
    check(q, 6'h00);
    check(qn, 6'h3f);
    drv.put(1, 0, 0, 6'h15, 4);
    drv.put(1, 0, 1, 6'h15, 4);
    check(q, 6'h00);
    drv.put(0, 0, 0, 6'h15, 4);
    drv.put(0, 1, 0, 6'h15, 4);
    check(q, 6'h15);
    drv.put(1, 1, 0, 6'h15, 4);
    check(q, 6'h00);
    check(qn, 6'h3f);
    drv.put(0, 1, 0, 6'h15, 4);
    check(q, 6'h00);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    srst = 1'h0;
    check(q, 6'h00);
    check(qn, 6'h3f);
    t_load();
    t_hold();
    t_clear();
    finish_test();
  end
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule
`default_nettype wire
